// ==== src/pfs_pkg.sv ====
`default_nettype none

package pfs_pkg;

    // Register port geometry
    localparam int          ADDR_W          = 10;
    localparam int          DATA_W          = 16;
    localparam logic [9:0]  DRV_CONFIG_ADDR = 10'h1C5;
    localparam logic [9:0]  DRV_STATUS_ADDR = 10'h1D2;

    // Config reset: recommended UV threshold code, all enables off
    localparam logic [15:0] CFG_RESET       = 16'h7C00;
    localparam logic [7:0]  DAC_CODE_MIN    = 8'h08;
    localparam logic [7:0]  DAC_CODE_MAX    = 8'hF8;

    // Status bit positions
    localparam int          STS_BOOST_UV    = 0;
    localparam int          STS_OVER_TEMP   = 1;
    localparam int          STS_DRV_EN      = 2;
    localparam int          STS_GATE_UV     = 3;
    localparam int          STS_FIVE_UV     = 4;
    localparam int          STS_FIVE_OV     = 5;
    localparam int          STS_READY       = 6;

    // Timing
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          MISS_GND_FLT_NS = 1300000;
    localparam int          GND_FLT_CYCLES  = MISS_GND_FLT_NS / CLK_PERIOD_NS;
    localparam int          READY_NS        = 300000;
    localparam int          READY_CYCLES    = READY_NS / CLK_PERIOD_NS;
    localparam int          BOOST_FLT_CYCLES = 4;

    // Analog monitor and pin levels, as they arrive
    typedef struct packed {
        logic drv_en;
        logic boost_fbk;
        logic ground_missing;
        logic vccp_uv;
        logic five_volt_undervoltage;
        logic five_volt_overvoltage;
        logic over_temp;
    } pfs_sense_t;

    // Driver configuration word layout
    typedef struct packed {
        logic [7:0] dac_code;
        logic [3:0] reserved;
        logic       boost_shutoff_en;
        logic       boost_uv_mode;
        logic       over_temp_irq_en;
        logic       boost_irq_en;
    } pfs_cfg_t;

endpackage

`default_nettype wire

// ==== src/pfs_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

module pfs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Levels
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] stage3_ff;
    logic [WIDTH-1:0] dout_ff;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            stage1_ff <= '0;
            stage2_ff <= '0;
            stage3_ff <= '0;
        end
        else
        begin
            stage1_ff <= din;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    // Change accepted only once two late stages agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                    dout_ff[i] <= 1'b0;
                else if (stage2_ff[i] == stage3_ff[i])
                    dout_ff[i] <= stage3_ff[i];
            end
        end
    endgenerate

    assign dout = dout_ff;

endmodule // pfs_sync

`default_nettype wire

// ==== src/pfs_filter.sv ====
`timescale 1ns/10ps
`default_nettype none

module pfs_filter #(
    parameter int CYCLES = 4,
    parameter int CNT_W  = $clog2(CYCLES + 1)
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Levels
    input  wire logic level_in,
    output logic      level_out
);

    logic [CNT_W-1:0] cnt_ff;
    logic             out_ff;

    // Count persistence, drop at once when the condition goes away
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            cnt_ff <= '0;
        else if (!level_in)
            cnt_ff <= '0;
        else if (cnt_ff != CNT_W'(CYCLES))
            cnt_ff <= cnt_ff + CNT_W'(1);
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            out_ff <= 1'b0;
        else
            out_ff <= level_in && (cnt_ff >= CNT_W'(CYCLES - 1));
    end

    assign level_out = out_ff;

    a_filt_release : assert property (@(posedge clk) disable iff (reset)
        !level_in |=> !level_out)
        else $error("Filter output held after input fell");

endmodule // pfs_filter

`default_nettype wire

// ==== src/pfs_monitor.sv ====
// What this block does
// - Boost UV mode select switches comparator divider from 1/32 to 1/4.
// - Boost comparator disables high-side pre-drivers only when shut-off enabled.
// - Boost UV goes high when boost below threshold, UV mode active and shut-off enabled.
// - Digital filter applied to boost comparator while UV mode active.
// - Boost UV, gate-supply UV and five-volt UV each force high-side drivers off.
// - Boost UV event sets status bit in driver status register.
// - Boost UV with its interrupt enabled raises interrupt at once.
// - Missing ground asserts gate-supply undervoltage, disabling all pre-drivers.
// - Missing ground must persist 1.3 ms before gate-supply UV asserts.
// - Overtemperature sets its bit in driver status register.
// - Overtemperature with its interrupt enabled raises interrupt at once.
// - Driver-enable pin low turns all pre-drivers off, core keeps running.
// - Driver status shows current driver-enable pin level.
// - Five-volt overvoltage switches device off, all drivers off, while it lasts.
// - Digital outputs ready within 300 us after reset release.
// - Boost comparator high above threshold, low below.
// - Threshold DAC takes unsigned 8-bit code from the core.
`timescale 1ns/10ps
`default_nettype none

module pfs_monitor #(
    parameter int GND_FLT_CYCLES   = pfs_pkg::GND_FLT_CYCLES,
    parameter int READY_CYCLES     = pfs_pkg::READY_CYCLES,
    parameter int BOOST_FLT_CYCLES = pfs_pkg::BOOST_FLT_CYCLES
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset,
    // Pins and analog monitors
    input  wire pfs_pkg::pfs_sense_t           sense_in,
    // Register port from the serial interface
    input  wire logic [pfs_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic [pfs_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                          reg_rd,
    output logic      [pfs_pkg::DATA_W-1:0]    reg_rdata,
    // Analog controls
    output logic                               boost_div_quarter,
    output logic                               boost_filter_on,
    output logic      [7:0]                    dac_boost_code,
    // Pre-driver gating
    output logic                               hs_predrv_en,
    output logic                               ls_predrv_en,
    output logic                               device_shutdown,
    // Monitor results
    output logic                               boost_undervoltage,
    output logic                               gate_supply_undervoltage,
    output logic                               digital_ready,
    output logic                               interrupt_request_n
);

    localparam int RDY_W = $clog2(READY_CYCLES + 1);

    pfs_pkg::pfs_sense_t           sense_s;
    pfs_pkg::pfs_cfg_t             cfg_ff;
    logic                          boost_low;
    logic                          boost_low_filt;
    logic                          ground_filt;
    logic                          boost_uv_ff;
    logic                          gate_uv_ff;
    logic                          boost_flag_ff;
    logic                          ot_flag_ff;
    logic                          nxt_boost_flag;
    logic                          nxt_ot_flag;
    logic                          status_read;
    logic [pfs_pkg::DATA_W-1:0]    status_word;
    logic [pfs_pkg::DATA_W-1:0]    rdata_ff;
    logic [RDY_W-1:0]              rdy_cnt_ff;
    logic                          ready_ff;
    logic                          hs_en_ff;
    logic                          ls_en_ff;
    logic                          shutdown_ff;
    logic                          div_quarter_ff;
    logic                          filter_on_ff;
    logic [7:0]                    dac_ff;
    logic                          irq_n_ff;

    pfs_sync #(
        .WIDTH ($bits(pfs_pkg::pfs_sense_t))
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .din   (sense_in),
        .dout  (sense_s)
    );

    assign boost_low = cfg_ff.boost_uv_mode && !sense_s.boost_fbk;

    pfs_filter #(
        .CYCLES (BOOST_FLT_CYCLES)
    ) u_boost_filt (
        .clk       (clk),
        .reset     (reset),
        .level_in  (boost_low),
        .level_out (boost_low_filt)
    );

    pfs_filter #(
        .CYCLES (GND_FLT_CYCLES)
    ) u_gnd_filt (
        .clk       (clk),
        .reset     (reset),
        .level_in  (sense_s.ground_missing),
        .level_out (ground_filt)
    );

    // lost ground folds into gate-supply UV
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            gate_uv_ff <= 1'b0;
        else
            gate_uv_ff <= ground_filt || sense_s.vccp_uv;
    end

    // Configuration register, reserved bits kept at zero
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            cfg_ff <= pfs_pkg::pfs_cfg_t'(pfs_pkg::CFG_RESET);
        else if (reg_wr && reg_addr == pfs_pkg::DRV_CONFIG_ADDR)
        begin
            cfg_ff          <= pfs_pkg::pfs_cfg_t'(reg_wdata);
            cfg_ff.reserved <= 4'h0;
        end
    end

    // divider and filter select follow UV mode
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            div_quarter_ff <= 1'b0;
            filter_on_ff   <= 1'b0;
            dac_ff         <= 8'h00;
        end
        else
        begin
            div_quarter_ff <= cfg_ff.boost_uv_mode;
            filter_on_ff   <= cfg_ff.boost_uv_mode;
            dac_ff         <= cfg_ff.dac_code;
        end
    end

    // boost UV gated by shut-off enable
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            boost_uv_ff <= 1'b0;
        else
            boost_uv_ff <= cfg_ff.boost_shutoff_en && cfg_ff.boost_uv_mode && boost_low_filt;
    end

    // Ready time after reset release
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            rdy_cnt_ff <= '0;
        else if (rdy_cnt_ff != RDY_W'(READY_CYCLES))
            rdy_cnt_ff <= rdy_cnt_ff + RDY_W'(1);
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            ready_ff <= 1'b0;
        else if (rdy_cnt_ff == RDY_W'(READY_CYCLES - 1))
            ready_ff <= 1'b1;
    end

    // Drivers held off until ready, so no glitch leaks during start
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            hs_en_ff    <= 1'b0;
            ls_en_ff    <= 1'b0;
            shutdown_ff <= 1'b1;
        end
        else
        begin
            // high-side also blocked by boost UV
            hs_en_ff    <= ready_ff && sense_s.drv_en && !gate_uv_ff
                           && !sense_s.five_volt_undervoltage
                           && !boost_uv_ff && !sense_s.five_volt_overvoltage;
            // lost ground stops low side too
            ls_en_ff    <= ready_ff && sense_s.drv_en && !gate_uv_ff
                           && !sense_s.five_volt_undervoltage
                           && !sense_s.five_volt_overvoltage;
            shutdown_ff <= sense_s.five_volt_overvoltage;
        end
    end

    assign status_read = reg_rd && reg_addr == pfs_pkg::DRV_STATUS_ADDR;

    // Sticky flags; a new event beats a clearing read
    always_comb
    begin
        nxt_boost_flag = boost_flag_ff;
        nxt_ot_flag    = ot_flag_ff;
        if (status_read)
        begin
            nxt_boost_flag = 1'b0;
            nxt_ot_flag    = 1'b0;
        end
        if (boost_uv_ff)
            nxt_boost_flag = 1'b1;
        if (sense_s.over_temp)
            nxt_ot_flag = 1'b1;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            boost_flag_ff <= 1'b0;
            ot_flag_ff    <= 1'b0;
        end
        else
        begin
            boost_flag_ff <= nxt_boost_flag;
            ot_flag_ff    <= nxt_ot_flag;
        end
    end

    // Interrupt line follows enabled flags
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            irq_n_ff <= 1'b1;
        else
            irq_n_ff <= !((nxt_boost_flag && cfg_ff.boost_irq_en)
                          || (nxt_ot_flag && cfg_ff.over_temp_irq_en));
    end

    always_comb
    begin
        status_word                         = '0;
        status_word[pfs_pkg::STS_BOOST_UV]  = boost_flag_ff;
        status_word[pfs_pkg::STS_OVER_TEMP] = ot_flag_ff;
        status_word[pfs_pkg::STS_DRV_EN]    = sense_s.drv_en;
        status_word[pfs_pkg::STS_GATE_UV]   = gate_uv_ff;
        status_word[pfs_pkg::STS_FIVE_UV]   = sense_s.five_volt_undervoltage;
        status_word[pfs_pkg::STS_FIVE_OV]   = sense_s.five_volt_overvoltage;
        status_word[pfs_pkg::STS_READY]     = ready_ff;
    end

    // Read data; unmapped addresses read zero
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            rdata_ff <= '0;
        else if (reg_rd)
        begin
            if (reg_addr == pfs_pkg::DRV_CONFIG_ADDR)
                rdata_ff <= cfg_ff;
            else if (reg_addr == pfs_pkg::DRV_STATUS_ADDR)
                rdata_ff <= status_word;
            else
                rdata_ff <= '0;
        end
    end

    assign reg_rdata                = rdata_ff;
    assign boost_div_quarter        = div_quarter_ff;
    assign boost_filter_on          = filter_on_ff;
    assign dac_boost_code           = dac_ff;
    assign hs_predrv_en             = hs_en_ff;
    assign ls_predrv_en             = ls_en_ff;
    assign device_shutdown          = shutdown_ff;
    assign boost_undervoltage       = boost_uv_ff;
    assign gate_supply_undervoltage = gate_uv_ff;
    assign digital_ready            = ready_ff;
    assign interrupt_request_n      = irq_n_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_div_mode_sel : assert property (
        boost_div_quarter == $past(cfg_ff.boost_uv_mode))
        else $error("Divider select does not follow UV mode");

    a_boost_gate : assert property (
        boost_undervoltage |-> $past(cfg_ff.boost_shutoff_en) && filter_on_ff)
        else $error("Boost UV without shut-off enable");

    a_boost_rise : assert property (
        cfg_ff.boost_shutoff_en && cfg_ff.boost_uv_mode && !sense_s.boost_fbk
        ##1 (cfg_ff.boost_shutoff_en && cfg_ff.boost_uv_mode
             && !sense_s.boost_fbk) [*5]
        |=> boost_undervoltage)
        else $error("Boost UV missed after filtered low");

    a_filter_mode : assert property (
        $rose(cfg_ff.boost_uv_mode) |=> boost_filter_on)
        else $error("Filter not on in UV mode");

    a_hs_uv_off : assert property (
        (boost_undervoltage || gate_supply_undervoltage
         || sense_s.five_volt_undervoltage) |=> !hs_predrv_en)
        else $error("High side on during undervoltage");

    a_status_boost : assert property (
        boost_undervoltage |=> reg_rd && reg_addr == pfs_pkg::DRV_STATUS_ADDR
        |=> reg_rdata[pfs_pkg::STS_BOOST_UV])
        else $error("Boost UV status bit not set");

    a_irq_boost : assert property (
        boost_undervoltage && cfg_ff.boost_irq_en |=> !interrupt_request_n)
        else $error("No interrupt on boost UV");

    a_gnd_all_off : assert property (
        gate_supply_undervoltage |=> !hs_predrv_en && !ls_predrv_en)
        else $error("Driver on with gate supply UV");

    a_irq_ot : assert property (
        sense_s.over_temp && cfg_ff.over_temp_irq_en |=> !interrupt_request_n)
        else $error("No interrupt on overtemperature");

    a_ot_status : assert property (
        sense_s.over_temp |=> ot_flag_ff)
        else $error("Overtemperature flag not set");

    a_drven_off : assert property (
        !sense_s.drv_en |=> !hs_predrv_en && !ls_predrv_en)
        else $error("Driver on with enable pin low");

    a_drven_read : assert property (
        status_read |=> reg_rdata[pfs_pkg::STS_DRV_EN] == $past(sense_s.drv_en))
        else $error("Status enable bit wrong");

    a_ov_off : assert property (
        sense_s.five_volt_overvoltage
        |=> device_shutdown && !hs_predrv_en && !ls_predrv_en)
        else $error("Not shut down on overvoltage");

    a_ready_hold : assert property (
        !digital_ready |-> !hs_predrv_en && !ls_predrv_en)
        else $error("Driver on before ready");

    c_boost_uv  : cover property ($rose(boost_undervoltage));
    c_gnd_lost  : cover property ($rose(ground_filt));
    c_ot_irq    : cover property (sense_s.over_temp && !interrupt_request_n);
    c_drv_on    : cover property ($rose(hs_predrv_en));

endmodule // pfs_monitor

`default_nettype wire

// ==== test/pfs_host.sv ====
`timescale 1ns/10ps
`default_nettype none

module pfs_host (
    // Clock
    input  wire logic        clk,
    // Register port
    output logic [9:0]       reg_addr,
    output logic             reg_wr,
    output logic [15:0]      reg_wdata,
    output logic             reg_rd,
    input  wire logic [15:0] reg_rdata,
    // Driver-enable pin
    output logic             drv_en
);
    initial
    begin
        reg_addr  = 10'h000;
        reg_wr    = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd    = 1'b0;
        drv_en    = 1'b1;
    end

    task automatic set_enable(input logic v);
    begin
        @(negedge clk);
        drv_en = v;
    end
    endtask

    task automatic reg_write(input logic [9:0] a, input logic [15:0] d);
        logic [15:0] w;
    begin
        w = d;
        if (a == pfs_pkg::DRV_CONFIG_ADDR && d[2] && d[15:8] < pfs_pkg::DAC_CODE_MIN)
            w[15:8] = pfs_pkg::DAC_CODE_MIN;
        if (a == pfs_pkg::DRV_CONFIG_ADDR && d[2] && d[15:8] > pfs_pkg::DAC_CODE_MAX)
            w[15:8] = pfs_pkg::DAC_CODE_MAX;
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = w;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        // Released lines flip so stale values never look valid
        reg_addr  = ~a;
        reg_wdata = ~w;
    end
    endtask

    task automatic reg_read(input logic [9:0] a, output logic [15:0] d);
    begin
        @(negedge clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        @(negedge clk);
        d = reg_rdata;
    end
    endtask

    task automatic cfg_write(input logic [3:0] bits);
    begin
        reg_write(pfs_pkg::DRV_CONFIG_ADDR, {8'h7C, 4'h0, bits});
    end
    endtask
endmodule // pfs_host

`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module tb;
    typedef struct packed {
        logic [3:0]  cfg;
        logic [6:0]  sns;
        logic [5:0]  outs;
        logic [15:0] sts;
    } pfs_case_t;

    localparam logic [9:0] CFG = pfs_pkg::DRV_CONFIG_ADDR;
    localparam logic [9:0] STS = pfs_pkg::DRV_STATUS_ADDR;

    logic                clk;
    logic                reset;
    logic [5:0]          analog;
    logic                drv_en;
    pfs_pkg::pfs_sense_t sense_in;
    logic [9:0]          reg_addr;
    logic                reg_wr;
    logic [15:0]         reg_wdata;
    logic                reg_rd;
    logic [15:0]         reg_rdata;
    logic                boost_div_quarter;
    logic                boost_filter_on;
    logic [7:0]          dac_boost_code;
    logic                hs_predrv_en;
    logic                ls_predrv_en;
    logic                device_shutdown;
    logic                boost_undervoltage;
    logic                gate_supply_undervoltage;
    logic                digital_ready;
    logic                interrupt_request_n;
    logic [15:0]         rd;
    int                  bad_count;
    int                  check_count;
    pfs_case_t           cases [9];

    assign sense_in = {drv_en, analog};

    pfs_host u_pfs_host (
        .clk       (clk),
        .reg_addr  (reg_addr),
        .reg_wr    (reg_wr),
        .reg_wdata (reg_wdata),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata),
        .drv_en    (drv_en)
    );

    // Short filters keep the run brief
    pfs_monitor #(
        .GND_FLT_CYCLES   (20),
        .READY_CYCLES     (10),
        .BOOST_FLT_CYCLES (4)
    ) u_pfs_monitor (
        .clk                      (clk),
        .reset                    (reset),
        .sense_in                 (sense_in),
        .reg_addr                 (reg_addr),
        .reg_wr                   (reg_wr),
        .reg_wdata                (reg_wdata),
        .reg_rd                   (reg_rd),
        .reg_rdata                (reg_rdata),
        .boost_div_quarter        (boost_div_quarter),
        .boost_filter_on          (boost_filter_on),
        .dac_boost_code           (dac_boost_code),
        .hs_predrv_en             (hs_predrv_en),
        .ls_predrv_en             (ls_predrv_en),
        .device_shutdown          (device_shutdown),
        .boost_undervoltage       (boost_undervoltage),
        .gate_supply_undervoltage (gate_supply_undervoltage),
        .digital_ready            (digital_ready),
        .interrupt_request_n      (interrupt_request_n)
    );

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    begin
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    end
    endtask

    task automatic tally_and_finish();
    begin
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        reset       = 1'b1;
        analog      = 6'h20;
        bad_count   = 0;
        check_count = 0;
        // Outputs: hs ls boost_uv gate_uv shutdown irq_n
        cases[0] = {4'hF, 7'h40, 6'b011000, 16'h0045};
        cases[1] = {4'h4, 7'h40, 6'b110001, 16'h0044};
        cases[2] = {4'h0, 7'h20, 6'b000001, 16'h0040};
        cases[3] = {4'h2, 7'h61, 6'b110000, 16'h0046};
        cases[4] = {4'h0, 7'h61, 6'b110001, 16'h0046};
        cases[5] = {4'h0, 7'h64, 6'b000001, 16'h0054};
        cases[6] = {4'h0, 7'h70, 6'b000101, 16'h004C};
        cases[7] = {4'h0, 7'h62, 6'b000011, 16'h0064};
        cases[8] = {4'h0, 7'h68, 6'b000101, 16'h004C};
        repeat (12) @(negedge clk);
        check("shutdown in reset", device_shutdown, 1'b1);
        reset = 1'b0;
        for (int i = 0; i < 14 && digital_ready !== 1'b1; i++)
            @(negedge clk);
        check("digital_ready", digital_ready, 1'b1);
        u_pfs_host.reg_read(CFG, rd);
        check("config reset", rd, pfs_pkg::CFG_RESET);
        check("dac reset", dac_boost_code, 8'h7C);
        u_pfs_host.reg_write(CFG, 16'h7CFF);
        u_pfs_host.reg_read(CFG, rd);
        check("config reserved", rd, 16'h7C0F);
        check("divider quarter", boost_div_quarter, 1'b1);
        check("filter on", boost_filter_on, 1'b1);
        u_pfs_host.reg_write(CFG, 16'h0004);
        repeat (3) @(negedge clk);
        check("dac low code", dac_boost_code, 8'h08);
        u_pfs_host.reg_write(CFG, 16'hFF04);
        u_pfs_host.reg_write(STS, 16'hFFFF);
        u_pfs_host.reg_write(10'h100, 16'h0000);
        u_pfs_host.reg_read(CFG, rd);
        check("config kept", rd, 16'hF804);
        check("dac high code", dac_boost_code, 8'hF8);
        u_pfs_host.reg_read(10'h100, rd);
        check("unmapped read", rd, 16'h0000);
        u_pfs_host.reg_read(STS, rd);
        check("status idle", rd, 16'h0044);
        u_pfs_host.cfg_write(4'h0);
        repeat (3) @(negedge clk);
        check("divider back", boost_div_quarter, 1'b0);
        $display("test registers done");
        // Ground loss must outlast the filter
        analog = 6'h30;
        repeat (15) @(negedge clk);
        check("ground early", gate_supply_undervoltage, 1'b0);
        repeat (25) @(negedge clk);
        check("ground late", gate_supply_undervoltage, 1'b1);
        analog = 6'h20;
        repeat (40) @(negedge clk);
        $display("test ground filter done");
        foreach (cases[k])
        begin
            u_pfs_host.cfg_write(cases[k].cfg);
            u_pfs_host.set_enable(cases[k].sns[6]);
            analog = cases[k].sns[5:0];
            repeat (40) @(negedge clk);
            check("hs_predrv_en", hs_predrv_en, cases[k].outs[5]);
            check("ls_predrv_en", ls_predrv_en, cases[k].outs[4]);
            check("boost_uv", boost_undervoltage, cases[k].outs[3]);
            check("gate_uv", gate_supply_undervoltage, cases[k].outs[2]);
            check("shutdown", device_shutdown, cases[k].outs[1]);
            check("irq_n", interrupt_request_n, cases[k].outs[0]);
            u_pfs_host.reg_read(STS, rd);
            check("status", rd, cases[k].sts);
            u_pfs_host.set_enable(1'b1);
            analog = 6'h20;
            repeat (40) @(negedge clk);
            u_pfs_host.reg_read(STS, rd);
            u_pfs_host.reg_read(STS, rd);
            check("status cleared", rd, 16'h0044);
            check("irq_n idle", interrupt_request_n, 1'b1);
            $display("test case %0d done", k);
        end
        tally_and_finish();
    end
endmodule // tb

`default_nettype wire
